// [hw/can_irq_filter.sv]
// Interrupt, error classification and acceptance filter for a CAN controller.
// Assumes a bit stream processor supplying per-bit context, error counters,
// receive buffer occupancy and a message summary; Avalon-MM register slave.
//
// Behaviour
// - Interrupt output high until status read
// - Eight interrupt sources provided
// - Alarm on bus-off or count above limit
// - Overflow when buffer holds over 96
// - Passive interrupt at count 128 or more
// - Active, passive, bus-off from counters
// - Arbitration lost: interrupt, capture position
// - Bus error: interrupt, capture position
// - Bit error: driven differs from sampled
// - Six equal bits in stuffed region
// - Received CRC mismatch flags error
// - Illegal fixed field level flags error
// - Recessive ACK slot while sending
// - Mask bit one means do not care
// - No data: match through RTR suffices
// - Single standard: bytes 0,1hi,2,3
// - Single extended: all bytes, skip 3[1:0]
// - Dual: accept if either filter matches
// - Dual standard filter layouts
// - Dual standard no data passes filter one
// - Dual extended: base plus five bits
// - Mode bit one selects single filter
// - Alarm limit resets to 0x60
`default_nettype none
module can_irq_filter (
    input  wire logic                      core_clk_i,        // Core clock
    input  wire logic                      rst_n_i,           // Async reset, low
    input  wire logic [7:0]                avs_address_i,     // Byte address
    input  wire logic                      avs_read_i,        // Read request
    input  wire logic                      avs_write_i,       // Write request
    input  wire logic [31:0]               avs_writedata_i,   // Write data
    input  wire logic [3:0]                avs_byteenable_i,  // Byte lanes
    output logic      [31:0]               avs_readdata_o,    // Read data
    output logic                           avs_waitrequest_o, // Stall
    input  wire can_filt_pkg::bitview_type bit_i,             // Per-bit context
    input  wire logic                      arb_lost_i,        // Arbitration lost pulse
    input  wire logic                      tx_done_i,         // Transmit done pulse
    input  wire logic                      wake_i,            // Wakeup event pulse
    input  wire logic [8:0]                tec_i,             // Transmit error count
    input  wire logic [7:0]                rec_i,             // Receive error count
    input  wire logic [7:0]                rx_fill_i,         // Buffer occupancy
    input  wire logic                      rx_done_i,         // Message complete pulse
    input  wire can_filt_pkg::frame_type   frame_i,           // Message summary
    output logic                           store_o,           // Store this message
    output logic                           bus_err_o,         // Bus error pulse
    output logic [1:0]                     node_state_o,      // Error state
    output logic                           irq_o              // Interrupt request
);
    // ==========================================================
    // State
    can_filt_pkg::state_type s;      // Registered state
    can_filt_pkg::state_type next_s; // Next state
    // Helper terms
    logic         acc;        // Bus access completes this edge
    logic [7:0]   set;        // Flags raised this cycle
    logic         irq_clr;    // Status read completes
    logic         accept;     // Message passes filter
    logic         nodata;     // Message has no data bytes
    logic         err_any;    // Any bus error this bit
    logic [2:0]   err_kind;   // Class of that error
    logic         alarm_c;    // Alarm condition level
    logic         pass_c;     // Passive condition level
    logic         ovf_c;      // Overflow condition level
    logic [8:0]   lim;        // Active alarm limit
    logic [3:0][7:0] msg;     // Message bytes as filter sees them
    logic         f_single;   // Single filter result
    logic         f_one;      // Dual filter one result
    logic         f_two;      // Dual filter two result

    // Byte compare: masked bits always pass
    function automatic logic byte_ok(input logic [7:0] c, input logic [7:0] m, input logic [7:0] v);
        byte_ok = &(~(c ^ v) | m);
    endfunction

    // ==========================================================
    // Bus handshake: one wait cycle, answer on the second edge
    assign acc               = (avs_read_i | avs_write_i) & s.ack;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s.ack;
    assign avs_readdata_o    = s.rdata;
    assign irq_clr           = acc & avs_read_i & (avs_address_i == can_filt_pkg::IRQ_OFS);
    assign irq_o             = |s.flags;
    assign node_state_o      = s.nstate;

    // ==========================================================
    // Error classification of the current bus bit, bit error first
    always_comb begin
        err_any  = 1'b0;
        err_kind = can_filt_pkg::ERR_BIT;
        if (bit_i.sample) begin
            if (bit_i.bit_win && !bit_i.stuff_bit && (bit_i.rx_bit != bit_i.tx_bit)) begin
                err_any  = 1'b1;
                err_kind = can_filt_pkg::ERR_BIT;
            end else if (bit_i.stuff_win && (bit_i.rx_bit == s.last) &&
                         (s.run == can_filt_pkg::STUFF_RUN - 3'h1)) begin
                err_any  = 1'b1;
                err_kind = can_filt_pkg::ERR_STUFF;
            end else if (!bit_i.tx_active && bit_i.crc_chk && (bit_i.crc_calc != bit_i.crc_rx)) begin
                err_any  = 1'b1;
                err_kind = can_filt_pkg::ERR_CRC;
            end else if (!bit_i.tx_active && bit_i.fixed_fld && !bit_i.rx_bit) begin
                err_any  = 1'b1;
                err_kind = can_filt_pkg::ERR_FORM;
            end else if (bit_i.tx_active && bit_i.ack_slot && bit_i.rx_bit) begin
                err_any  = 1'b1;
                err_kind = can_filt_pkg::ERR_ACK;
            end
        end
    end
    assign bus_err_o = err_any;

    // ==========================================================
    // Counter thresholds; basic mode uses the fixed alarm limit
    assign lim     = s.mode[can_filt_pkg::MODE_EXT_BIT] ? {1'b0, s.limit} : can_filt_pkg::BASIC_LIMIT;
    assign alarm_c = (tec_i >= can_filt_pkg::BUSOFF_LVL) || (tec_i > lim) ||
                     ({1'b0, rec_i} > lim);
    assign pass_c  = (tec_i >= can_filt_pkg::PASSIVE_LVL) ||
                     ({1'b0, rec_i} >= can_filt_pkg::PASSIVE_LVL);
    assign ovf_c   = rx_fill_i > can_filt_pkg::FIFO_OVF_LVL;

    // ==========================================================
    // Acceptance filter
    assign nodata = frame_i.rtr || (frame_i.dlc == 4'h0);
    always_comb begin
        // Message bytes in filter order per format
        if (frame_i.ide) begin
            msg[0] = frame_i.id[28:21];
            msg[1] = frame_i.id[20:13];
            msg[2] = frame_i.id[12:5];
            msg[3] = {frame_i.id[4:0], frame_i.rtr, 2'h0};
        end else begin
            msg[0] = frame_i.id[28:21];
            msg[1] = {frame_i.id[20:18], frame_i.rtr, 4'h0};
            msg[2] = frame_i.data0;
            msg[3] = frame_i.data1;
        end
        f_single = 1'b0;
        f_one    = 1'b0;
        f_two    = 1'b0;
        if (frame_i.ide) begin
            // Extended single: bits 1:0 of byte 3 unused
            f_single = byte_ok(s.code[0], s.mask[0], msg[0]) &&
                       byte_ok(s.code[1], s.mask[1], msg[1]) &&
                       byte_ok(s.code[2], s.mask[2], msg[2]) &&
                       byte_ok(s.code[3], s.mask[3] | 8'h03, msg[3]);
            // Extended dual: base identifier and top extension bits
            f_one = byte_ok(s.code[0], s.mask[0], msg[0]) &&
                    byte_ok(s.code[1], s.mask[1], msg[1]);
            f_two = byte_ok(s.code[2], s.mask[2], msg[0]) &&
                    byte_ok(s.code[3], s.mask[3], msg[1]);
        end else begin
            // Standard single: low nibble of byte 1 unused
            f_single = byte_ok(s.code[0], s.mask[0], msg[0]) &&
                       byte_ok(s.code[1], s.mask[1] | 8'h0F, msg[1]) &&
                       (nodata || byte_ok(s.code[2], s.mask[2], msg[2])) &&
                       (nodata || (frame_i.dlc == 4'h1) ||
                        byte_ok(s.code[3], s.mask[3], msg[3]));
            // Standard dual one: first data byte split over two nibbles
            f_one = byte_ok(s.code[0], s.mask[0], msg[0]) &&
                    byte_ok(s.code[1] | 8'h0F, s.mask[1] | 8'h0F, msg[1] | 8'h0F) &&
                    (nodata || (byte_ok({s.code[1][3:0], s.code[3][3:0]},
                                        {s.mask[1][3:0], s.mask[3][3:0]},
                                        frame_i.data0)));
            // Standard dual two: identifier and RTR only
            f_two = byte_ok(s.code[2], s.mask[2], msg[0]) &&
                    byte_ok({s.code[3][7:4], 4'h0}, {s.mask[3][7:4], 4'hF}, msg[1]);
        end
    end
    assign accept  = s.mode[can_filt_pkg::MODE_FSEL_BIT] ? f_single : (f_one || f_two);
    assign store_o = rx_done_i && accept;

    // ==========================================================
    // Interrupt events; only enabled sources latch
    always_comb begin
        set = 8'h00;
        set[can_filt_pkg::IRQ_RX]      = rx_done_i && accept;
        set[can_filt_pkg::IRQ_TX]      = tx_done_i;
        set[can_filt_pkg::IRQ_ALARM]   = alarm_c && !s.alarm_q;
        set[can_filt_pkg::IRQ_OVF]     = ovf_c && !s.ovf_q;
        set[can_filt_pkg::IRQ_WAKE]    = wake_i;
        set[can_filt_pkg::IRQ_PASSIVE] = pass_c && !s.pass_q;
        set[can_filt_pkg::IRQ_ARB]     = arb_lost_i;
        set[can_filt_pkg::IRQ_BUSERR]  = err_any;
        set = set & s.ie;
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.ack = (avs_read_i | avs_write_i) & ~s.ack;
        // Flags: only bits shown to software are cleared; a new set wins
        next_s.flags = (s.flags & ~(irq_clr ? s.rdata[7:0] : 8'h00)) | set;
        next_s.alarm_q = alarm_c;
        next_s.pass_q  = pass_c;
        next_s.ovf_q   = ovf_c;
        // Node state classification
        if (tec_i >= can_filt_pkg::BUSOFF_LVL) begin
            next_s.nstate = can_filt_pkg::NODE_BUSOFF;
        end else if (pass_c) begin
            next_s.nstate = can_filt_pkg::NODE_PASSIVE;
        end else begin
            next_s.nstate = can_filt_pkg::NODE_ACTIVE;
        end
        // Captures follow their events
        if (arb_lost_i) begin
            next_s.alc = {3'h0, bit_i.pos};
        end
        if (err_any) begin
            next_s.ecc = {err_kind, bit_i.pos};
        end
        // Run-length tracker for stuffing; reset outside the region
        if (bit_i.sample) begin
            next_s.last = bit_i.rx_bit;
            if (!bit_i.stuff_win || (bit_i.rx_bit != s.last)) begin
                next_s.run = 3'h1;
            end else if (s.run != can_filt_pkg::STUFF_RUN) begin
                next_s.run = s.run + 3'h1;
            end
        end
        // Read data fetched in the wait cycle
        if ((avs_read_i) && !s.ack) begin
            next_s.rdata = 32'h0000_0000;
            case (avs_address_i)
                can_filt_pkg::MODE_OFS:   next_s.rdata[7:0] = s.mode;
                can_filt_pkg::STATUS_OFS: next_s.rdata[1:0] = s.nstate;
                can_filt_pkg::IRQ_OFS:    next_s.rdata[7:0] = s.flags;
                can_filt_pkg::IE_OFS:     next_s.rdata[7:0] = s.ie;
                can_filt_pkg::ALC_OFS:    next_s.rdata[7:0] = s.alc;
                can_filt_pkg::ECC_OFS:    next_s.rdata[7:0] = s.ecc;
                can_filt_pkg::LIMIT_OFS:  next_s.rdata[7:0] = s.limit;
                default: begin
                    // Code and mask banks; other addresses read zero
                    if (avs_address_i[7:4] == can_filt_pkg::CODE0_OFS[7:4] && avs_address_i[1:0] == 2'h0) begin
                        next_s.rdata[7:0] = s.code[avs_address_i[3:2]];
                    end else if (avs_address_i[7:4] == can_filt_pkg::MASK0_OFS[7:4] &&
                                 avs_address_i[1:0] == 2'h0) begin
                        next_s.rdata[7:0] = s.mask[avs_address_i[3:2]];
                    end
                end
            endcase
        end
        // Writes take effect on the answering edge, lane 0 only
        if (acc && avs_write_i && avs_byteenable_i[0]) begin
            case (avs_address_i)
                can_filt_pkg::MODE_OFS:  next_s.mode  = avs_writedata_i[7:0];
                can_filt_pkg::IE_OFS:    next_s.ie    = avs_writedata_i[7:0];
                can_filt_pkg::LIMIT_OFS: next_s.limit = avs_writedata_i[7:0];
                default: begin
                    if (avs_address_i[7:4] == can_filt_pkg::CODE0_OFS[7:4] && avs_address_i[1:0] == 2'h0) begin
                        next_s.code[avs_address_i[3:2]] = avs_writedata_i[7:0];
                    end else if (avs_address_i[7:4] == can_filt_pkg::MASK0_OFS[7:4] &&
                                 avs_address_i[1:0] == 2'h0) begin
                        next_s.mask[avs_address_i[3:2]] = avs_writedata_i[7:0];
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // State register; the alarm limit comes up at 0x60, run length and last level at one, all else cleared
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s       <= '0;
            s.limit <= can_filt_pkg::LIMIT_RESET;
            s.run   <= 3'h1;
            s.last  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    irq_hold_a: assert property (irq_o && !irq_clr |=> irq_o)
        else $error("interrupt dropped without status read");
    rx_irq_a: assert property (rx_done_i && s.ie[0] && !s.flags[0] |=> s.flags[0] == $past(accept))
        else $error("receive flag does not follow acceptance");
    alarm_irq_a: assert property ($rose(alarm_c) && s.ie[2] |=> s.flags[2])
        else $error("alarm flag missed");
    ovf_irq_a: assert property (rx_fill_i > 8'h60 && !s.ovf_q && s.ie[3] |=> s.flags[3])
        else $error("overflow flag missed");
    passive_irq_a: assert property ($rose(pass_c) && s.ie[5] |=> s.flags[5] && s.nstate != 2'h0)
        else $error("passive flag missed");
    busoff_state_a: assert property (tec_i >= 9'h100 |=> node_state_o == 2'h2)
        else $error("bus-off not shown");
    arb_capture_a: assert property (arb_lost_i |=> s.alc[4:0] == $past(bit_i.pos))
        else $error("arbitration position not captured");
    err_capture_a: assert property (err_any |=> s.ecc == {$past(err_kind), $past(bit_i.pos)})
        else $error("error code not captured");
    bit_err_a: assert property (bit_i.sample && bit_i.bit_win && !bit_i.stuff_bit &&
                                bit_i.rx_bit != bit_i.tx_bit |-> bus_err_o)
        else $error("bit error missed");
    ack_err_a: assert property (bit_i.sample && bit_i.tx_active && bit_i.ack_slot && bit_i.rx_bit |-> err_any)
        else $error("ack error missed");
    mask_all_a: assert property (s.mask == 32'hFFFF_FFFF && !frame_i.ide |-> accept)
        else $error("all-masked filter rejected message");
    limit_reset_a: assert property ($rose(rst_n_i) |-> s.limit == 8'h60)
        else $error("alarm limit reset value wrong");

    rx_store_c: cover property (rx_done_i && accept);
    rx_reject_c: cover property (rx_done_i && !accept);
    stuff_err_c: cover property (err_any && err_kind == 3'h1);
    irq_clear_c: cover property (irq_clr ##1 !irq_o);
endmodule
`default_nettype wire

// [hw/can_filt_pkg.sv]
// Shared constants and carrier types for the CAN interrupt and acceptance block.
// Assumes a byte-addressed 32-bit Avalon-MM register window and one core clock.
`default_nettype none
package can_filt_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] MODE_OFS    = 8'h00; // Mode bits
    localparam logic [7:0] STATUS_OFS  = 8'h08; // Node error state
    localparam logic [7:0] IRQ_OFS     = 8'h0C; // Sticky flags, read clears
    localparam logic [7:0] IE_OFS      = 8'h10; // Interrupt enables
    localparam logic [7:0] ALC_OFS     = 8'h2C; // Arbitration-lost position
    localparam logic [7:0] ECC_OFS     = 8'h30; // Error code capture
    localparam logic [7:0] LIMIT_OFS   = 8'h34; // Error alarm limit
    localparam logic [7:0] CODE0_OFS   = 8'h40; // Code bytes 0..3 at +4 steps
    localparam logic [7:0] MASK0_OFS   = 8'h50; // Mask bytes 0..3 at +4 steps
    // ==========================================================
    // Field positions and reset values
    localparam int          MODE_FSEL_BIT = 3;      // filter_mode_select
    localparam int          MODE_EXT_BIT  = 7;      // Extended mode
    localparam logic [7:0]  LIMIT_RESET   = 8'h60;  // Alarm limit after reset
    localparam logic [8:0]  BASIC_LIMIT   = 9'h060; // Fixed limit in basic mode
    localparam logic [7:0]  FIFO_OVF_LVL  = 8'h60;  // Occupancy threshold
    localparam logic [8:0]  PASSIVE_LVL   = 9'h080; // Error passive from here
    localparam logic [8:0]  BUSOFF_LVL    = 9'h100; // Bus-off from here
    localparam logic [2:0]  STUFF_RUN     = 3'h6;   // Equal bits that are illegal
    // ==========================================================
    // Interrupt flag positions
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_ALARM = 2;
    localparam int IRQ_OVF = 3;
    localparam int IRQ_WAKE = 4;
    localparam int IRQ_PASSIVE = 5;
    localparam int IRQ_ARB = 6;
    localparam int IRQ_BUSERR = 7;
    // ==========================================================
    // Error classes held in error code capture bits 7:5
    typedef enum logic [2:0] {
        ERR_BIT   = 3'h0,
        ERR_STUFF = 3'h1,
        ERR_CRC   = 3'h2,
        ERR_FORM  = 3'h3,
        ERR_ACK   = 3'h4
    } err_kind_type;
    typedef enum logic [1:0] {
        NODE_ACTIVE  = 2'h0,
        NODE_PASSIVE = 2'h1,
        NODE_BUSOFF  = 2'h2
    } node_state_type;
    // ==========================================================
    // Received message summary from the bit stream processor
    typedef struct packed {
        logic        ide;   // Extended format
        logic        rtr;   // Remote request
        logic [3:0]  dlc;   // Data length code
        logic [28:0] id;    // Identifier, standard in 28:18
        logic [7:0]  data0; // First data byte
        logic [7:0]  data1; // Second data byte
    } frame_type;
    // Per-bit view of the bus from the bit stream processor
    typedef struct packed {
        logic        sample;    // One-cycle strobe per bus bit
        logic        rx_bit;    // Sampled bus level, 0 dominant
        logic        tx_bit;    // Level this node drives
        logic        tx_active; // Node is transmitter
        logic        stuff_bit; // Current bit is a stuff bit
        logic        bit_win;   // Bit-compare window
        logic        stuff_win; // SOF through CRC sequence
        logic        fixed_fld; // Fixed-form field bit
        logic        ack_slot;  // ACK slot bit
        logic        crc_chk;   // CRC compare strobe
        logic [14:0] crc_calc;  // Locally computed CRC
        logic [14:0] crc_rx;    // Received CRC sequence
        logic [4:0]  pos;       // Bit stream position
    } bitview_type;
    // Whole state of the block
    typedef struct packed {
        logic [7:0]       flags;   // Sticky interrupt flags
        logic [7:0]       ie;      // Enables
        logic [7:0]       mode;    // Mode register
        logic [7:0]       limit;   // error_alarm_limit
        logic [7:0]       alc;     // Arbitration-lost capture
        logic [7:0]       ecc;     // Error code capture
        logic [3:0][7:0]  code;    // accept_code_byte0..3
        logic [3:0][7:0]  mask;    // accept_mask_byte0..3
        logic             ack;     // Bus answer phase
        logic [31:0]      rdata;   // Read data
        logic [2:0]       run;     // Equal-level run length
        logic             last;    // Previous sampled level
        logic             alarm_q; // Previous alarm condition
        logic             pass_q;  // Previous passive condition
        logic             ovf_q;   // Previous overflow condition
        node_state_type   nstate;  // Node error state
    } state_type;
endpackage
`default_nettype wire

// [verification/can_node_model.sv]
// Far-side node model: plays received bus bits into the per-bit view.
// Assumes the bench clock; one bus bit per clock cycle.
`default_nettype none
module can_node_model (
    input  wire logic                   core_clk_i, // Clock
    output var can_filt_pkg::bitview_type bit_o     // Per-bit context
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus is recessive, position parked at 15
    initial bit_o = '{rx_bit: 1'b1, tx_bit: 1'b1, pos: 5'h0F, default: '0};
    // ==========================================================
    // Plays a pattern MSB first inside the stuffed region
    task automatic play(input logic [7:0] pat);
        for (int i = 7; i >= 0; i--) begin
            @(posedge core_clk_i);
            bit_o <= '{sample: 1'b1, rx_bit: pat[i], tx_bit: pat[i], stuff_win: 1'b1, pos: 5'(15 - i), default: '0};
        end
        @(posedge core_clk_i);
        bit_o <= '{rx_bit: 1'b1, tx_bit: 1'b1, pos: 5'h0F, default: '0};
    endtask
    // Presents one bus bit with the given context, then idles
    task automatic put(input can_filt_pkg::bitview_type b);
        @(posedge core_clk_i);
        bit_o <= b;
        @(posedge core_clk_i);
        bit_o <= '{rx_bit: 1'b1, tx_bit: 1'b1, pos: 5'h0F, default: '0};
    endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Bench: Avalon-MM register tasks, event, error state and filter tests.
// Assumes the node model drives the per-bit view.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Stimulus and observed signals
    logic                      clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, arb = 1'b0, rxd = 1'b0;
    logic                      txd = 1'b0, wak = 1'b0;
    logic [7:0]                adr = '0, rec = '0, fill = 8'h60;
    logic [8:0]                tec = '0;
    logic [31:0]               wd = '0, rdata, q;
    logic                      wq, store, berr, irq;
    logic [1:0]                nst;
    can_filt_pkg::bitview_type bv;
    can_filt_pkg::frame_type   fr = '0;
    int                        failures = 0, total_checks = 0, cycles = 0, berr_n = 0;
    always #2 clk = ~clk;
    can_irq_filter DUT (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wq), .bit_i(bv), .arb_lost_i(arb), .tx_done_i(txd), .wake_i(wak),
        .tec_i(tec), .rec_i(rec), .rx_fill_i(fill), .rx_done_i(rxd), .frame_i(fr),
        .store_o(store), .bus_err_o(berr), .node_state_o(nst), .irq_o(irq));
    can_node_model node (.core_clk_i(clk), .bit_o(bv));
    // ==========================================================
    // Verdict, comparison and bus tasks
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Holds the request until waitrequest is seen low, then takes data
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, '0);
        chk(q, e);
    endtask
    task automatic cnt(input logic [8:0] t, input logic [7:0] r, input logic [1:0] e);
        @(posedge clk);
        tec <= t;
        rec <= r;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({30'h0, nst}, {30'h0, e});
    endtask
    // One-cycle message summary with two don't-care data bytes
    task automatic frame_chk(input logic x, input logic [28:0] fid, input logic e);
        @(posedge clk);
        fr <= '{ide: x, rtr: 1'b0, dlc: 4'h2, id: fid, data0: 8'h33, data1: 8'h33};
        rxd <= 1'b1;
        @(negedge clk);
        chk({31'h0, store}, {31'h0, e});
        @(posedge clk);
        rxd <= 1'b0;
    endtask
    // Counts classified bus errors seen at rising edges
    always @(posedge clk) begin
        if (berr === 1'b1) berr_n <= berr_n + 1;
    end
    // Hang guard: about 120 cycles are expected
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end
    // ==========================================================
    // Test sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rchk(can_filt_pkg::LIMIT_OFS, 32'h60);
        rchk(8'hFC, 32'h0);
        acc(1'b1, can_filt_pkg::IE_OFS, 32'hFF);
        @(posedge clk);
        arb <= 1'b1;
        @(posedge clk);
        arb <= 1'b0;
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        rchk(can_filt_pkg::ALC_OFS, 32'h0F);
        node.play(8'h03);
        rchk(can_filt_pkg::ECC_OFS, 32'h2D);
        node.put(can_filt_pkg::bitview_type'{sample: 1'b1, tx_active: 1'b1, ack_slot: 1'b1,
                 rx_bit: 1'b1, tx_bit: 1'b1, pos: 5'h1A, default: '0});
        rchk(can_filt_pkg::ECC_OFS, 32'h9A);
        chk(32'(berr_n), 32'h2);
        rchk(can_filt_pkg::IRQ_OFS, 32'hC0);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk);
        txd <= 1'b1;
        wak <= 1'b1;
        fill <= 8'h61;
        @(posedge clk);
        txd <= 1'b0;
        wak <= 1'b0;
        rchk(can_filt_pkg::IRQ_OFS, 32'h1A);
        $display("event test done");
        cnt(9'h07F, 8'h7F, 2'h0);
        cnt(9'h000, 8'h80, 2'h1);
        rchk(can_filt_pkg::IRQ_OFS, 32'h24);
        cnt(9'h100, 8'h00, 2'h2);
        cnt(9'h000, 8'h00, 2'h0);
        acc(1'b1, can_filt_pkg::LIMIT_OFS, 32'h10);
        acc(1'b1, can_filt_pkg::MODE_OFS, 32'h80);
        cnt(9'h011, 8'h00, 2'h0);
        rchk(can_filt_pkg::IRQ_OFS, 32'h04);
        $display("error state test done");
        acc(1'b1, can_filt_pkg::MODE_OFS, 32'h08);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, can_filt_pkg::CODE0_OFS + 8'(4 * i), (32'h000040A5 >> (8 * i)) & 32'hFF);
            acc(1'b1, can_filt_pkg::MASK0_OFS + 8'(4 * i), (32'hFFFF0F00 >> (8 * i)) & 32'hFF);
        end
        frame_chk(1'b0, {11'h52A, 18'h0}, 1'b1);
        rchk(can_filt_pkg::IRQ_OFS, 32'h01);
        frame_chk(1'b0, {11'h12A, 18'h0}, 1'b0);
        frame_chk(1'b1, {11'h52A, 18'h0}, 1'b1);
        frame_chk(1'b1, {11'h12A, 18'h0}, 1'b0);
        acc(1'b1, can_filt_pkg::MODE_OFS, 32'h00);
        frame_chk(1'b0, {11'h12A, 18'h0}, 1'b1);
        rchk(can_filt_pkg::MASK0_OFS + 8'h04, 32'h0F);
        $display("filter test done");
        conclude();
    end
endmodule
`default_nettype wire
